// ==== hw/sph_pkg.sv ====
// shared constants and types of the serial packet host interface
package sph_pkg;
  // ==========================================================================
  // clock and link rates
  localparam logic [31:0] CLK_HZ       = 32'h0098_9680;
  localparam logic [23:0] RATE_DEFAULT = 24'h00_9600;
  localparam logic [23:0] RATE_MAX     = 24'h01_C200;
  // ==========================================================================
  // user ram layout
  localparam logic [7:0]  RATE_WORD    = 8'hB1;
  localparam logic [7:0]  ADDR_WORD    = 8'hBF;
  localparam logic [23:0] ADDR_RESET   = 24'hFF_FFC0;
  localparam logic [15:0] BYTES_TOTAL  = 16'h0300;
  // ==========================================================================
  // packet framing and reply codes
  localparam logic [7:0]  HDR          = 8'hAA;
  localparam logic [7:0]  MIN_COUNT    = 8'h03;
  localparam logic [7:0]  RD_MAX       = 8'hFC;
  localparam logic [7:0]  ACK_DATA     = 8'hAA;
  localparam logic [7:0]  ACK          = 8'hAD;
  localparam logic [7:0]  NACK         = 8'hB0;
  localparam logic [7:0]  NOT_IMPL     = 8'hBC;
  localparam logic [7:0]  BAD_SUM      = 8'hBD;
  localparam logic [7:0]  OVERFLOW     = 8'hBF;
  // ==========================================================================
  // command groups, upper nibble
  localparam logic [3:0]  CMD_ADDR     = 4'hA;
  localparam logic [3:0]  CMD_SEL      = 4'hC;
  localparam logic [3:0]  CMD_WR       = 4'hD;
  localparam logic [3:0]  CMD_RD       = 4'hE;
  // ==========================================================================
  // modes and states
  typedef enum logic [1:0] {
    MODE_SPI  = 2'b00,
    MODE_UART = 2'b01,
    MODE_I2C  = 2'b10
  } sph_mode_e;
  typedef enum logic [2:0] {
    ST_HUNT  = 3'b000,
    ST_COUNT = 3'b001,
    ST_BODY  = 3'b010,
    ST_SUM   = 3'b011,
    ST_EXEC  = 3'b100,
    ST_REPLY = 3'b101
  } sph_state_e;
endpackage : sph_pkg

// ==== hw/sph_uart_rx.sv ====
// uart byte receiver, 8n1
`timescale 1ns/1ns
module sph_uart_rx (
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        rx_in,
  input  wire logic [15:0] bit_cycles_in,
  output logic             byte_valid_out,
  output logic [7:0]       byte_out
);
  typedef struct packed {
    logic [1:0]  ph;
    logic [15:0] cnt;
    logic [3:0]  bits;
    logic [7:0]  sh;
    logic        valid;
  } sph_rx_s;
  sph_rx_s r;
  sph_rx_s next_r;
  // ==========================================================================
  // bit timing: wait half a bit, then sample each bit centre
  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    if (r.ph == 2'b00) begin
      if (!rx_in && bit_cycles_in != 16'h0000) begin
        next_r.ph = 2'b01;
        next_r.cnt = {1'b0, bit_cycles_in[15:1]};
      end
    end else if (r.cnt != 16'h0000) begin
      next_r.cnt = r.cnt - 16'h0001;
    end else begin
      next_r.cnt = bit_cycles_in - 16'h0001;
      if (r.ph == 2'b01) begin
        next_r.ph = rx_in ? 2'b00 : 2'b10;
        next_r.bits = 4'h0;
      end else if (r.bits != 4'h8) begin
        next_r.sh = {rx_in, r.sh[7:1]};
        next_r.bits = r.bits + 4'h1;
      end else begin
        // a low stop bit is a framing error: byte dropped
        next_r.valid = rx_in;
        next_r.ph = 2'b00;
      end
    end
  end
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign byte_valid_out = r.valid;
  assign byte_out = r.sh;
endmodule : sph_uart_rx

// ==== hw/sph_fifo2.sv ====
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ns
module sph_fifo2 (
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  input  wire logic       in_valid_in,
  output logic            in_ready_out,
  input  wire logic [7:0] in_data_in,
  output logic            out_valid_out,
  input  wire logic       out_ready_in,
  output logic [7:0]      out_data_out
);
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic            wp;
    logic            rp;
    logic [1:0]      fill;
  } sph_buf_s;
  sph_buf_s r;
  sph_buf_s next_r;
  logic     push;
  logic     pop;
  assign in_ready_out = (r.fill != 2'b10);
  assign out_valid_out = (r.fill != 2'b00);
  assign out_data_out = r.mem[r.rp];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = in_data_in;
      next_r.wp = ~r.wp;
    end
    if (pop) begin
      next_r.rp = ~r.rp;
    end
    next_r.fill = r.fill + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  buf_full_c: cover property (r.fill == 2'b10);
endmodule : sph_fifo2

// ==== hw/sph_host_if.sv ====
// packet engine, user ram and uart transmitter of the host interface
`timescale 1ns/1ns
// Contract
// RL1 - select pins latched after reset pick exactly one of spi, uart, i2c
// RL2 - system holds the select pins steady 10ms after any reset
// RL3 - user ram is 256 words of 24 bits
// RL4 - uart runs 38400 baud 8n1 out of reset
// RL5 - rate comes from the rate word, capped 115200, used only after reset
// RL6 - direction pin asserted while this target is selected; code asserts it in uart mode only
// RL7 - identity is device address plus one
// RL8 - software writes ones into address word bits 23 to 6
// RL9 - identity zero never matches and deselects everyone
// RL10 - straps both low give identity 1, selected out of reset
// RL11 - integrity checked before acting; decode failures get a fail code
// RL12 - no reply at all while not selected
// RL13 - master deselects all, selects one, awaits ack before access
// RL14 - packet is header, count, payload, checksum
// RL15 - last byte is a modulo-256 sum of the packet
// RL16 - multibyte values travel low byte first
// RL17 - several commands per packet only when already selected
// RL18 - a0 clears pointer, a1 low, a2 high, a3 both bytes
// RL19 - c0 deselects, c1 to ce by nibble, cf by next byte, all acked
// RL20 - d0 writes rest of payload, d1 to df write nibble bytes
// RL21 - e0 reads count from next byte, e1 to ef read nibble bytes
// RL22 - invalid, unused and reserved commands are never executed
// RL23 - single byte reply: ad acknowledge, b0 to bf failures
// RL24 - read reply is aa, count, data, checksum
// RL25 - pointer moves past the last byte read or written
// RL26 - master times out after about fifty byte times and resends
// RL27 - while deselected only selection commands act
module sph_host_if (
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  input  wire logic       host_if_select_a_in,
  input  wire logic       host_if_select_b_in,
  input  wire logic       addr_strap_a_in,
  input  wire logic       addr_strap_b_in,
  input  wire logic       uart_rx_in,
  output logic            uart_tx_out,
  output logic            shared_select_direction_pin_out,
  output logic [1:0]      host_mode_out,
  output logic [7:0]      target_identity_out
);
  typedef struct packed {
    logic                   started;
    sph_pkg::sph_mode_e     mode;
    logic [7:0]             identity;
    logic                   selected;
    logic                   was_sel;
    logic [15:0]            bit_cycles;
    sph_pkg::sph_state_e    st;
    logic [7:0]             idx;
    logic [7:0]             sum;
    logic [7:0]             plen;
    logic [7:0]             ep;
    logic [7:0]             cur;
    logic [7:0]             need;
    logic [7:0]             code;
    logic                   fail;
    logic                   rd_req;
    logic [7:0]             rd_len;
    logic [15:0]            rd_ptr;
    logic [15:0]            ptr;
    logic [8:0]             rp;
    logic [7:0]             rsum;
    logic [252:0][7:0]      pkt;
    logic [255:0][23:0]     ram;
    logic [9:0]             tx_sh;
    logic [3:0]             tx_bits;
    logic [15:0]            tx_cnt;
  } sph_host_s;
  sph_host_s   r;
  sph_host_s   next_r;
  logic [1:0]  rst_sync;
  logic        reset_n_sync;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        push_valid;
  logic        push_ready;
  logic [7:0]  push_data;
  logic        tx_valid;
  logic        tx_ready;
  logic [7:0]  tx_data;
  logic        wr_step;
  logic [7:0]  b;
  // ==========================================================================
  // helpers
  function automatic sph_pkg::sph_mode_e sph_decode_mode(input logic a, input logic sb);
    if (!a) begin
      return sph_pkg::MODE_SPI;
    end else if (!sb) begin
      return sph_pkg::MODE_UART;
    end
    return sph_pkg::MODE_I2C;
  endfunction : sph_decode_mode
  function automatic logic [15:0] sph_bit_cycles(input logic [23:0] rate);
    logic [23:0] rr;
    logic [31:0] q;
    rr = (rate == 24'h00_0000) ? sph_pkg::RATE_DEFAULT : rate;
    rr = (rr > sph_pkg::RATE_MAX) ? sph_pkg::RATE_MAX : rr;
    q = sph_pkg::CLK_HZ / {8'h00, rr};
    // rates too slow for the counter fall back to the default
    if (q[31:16] != 16'h0000) begin
      q = sph_pkg::CLK_HZ / {8'h00, sph_pkg::RATE_DEFAULT};
    end
    return q[15:0];
  endfunction : sph_bit_cycles
  // byte address to {in range, word, lane}; lane 0 is the low byte
  function automatic logic [10:0] sph_locate(input logic [15:0] a);
    logic [15:0] w;
    logic [15:0] l;
    w = a / 16'h0003;
    l = a - w * 16'h0003;
    return {a < sph_pkg::BYTES_TOTAL, w[7:0], l[1:0]};
  endfunction : sph_locate
  function automatic logic [7:0] sph_get(input logic [255:0][23:0] m, input logic [15:0] a);
    logic [10:0] loc;
    loc = sph_locate(a);
    return loc[10] ? m[loc[9:2]][{loc[1:0], 3'b000} +: 8] : 8'h00;
  endfunction : sph_get
  function automatic sph_host_s sph_read_start(input sph_host_s s, input logic [7:0] len);
    sph_host_s o;
    o = s;
    // one read per packet; data plus framing must fit one count byte
    if (s.rd_req || len > sph_pkg::RD_MAX) begin
      o.fail = 1'b1;
      o.code = s.rd_req ? sph_pkg::NACK : sph_pkg::OVERFLOW;
      o.st = sph_pkg::ST_REPLY;
    end else begin
      o.rd_req = 1'b1;
      o.rd_len = len;
      o.rd_ptr = s.ptr;
      o.ptr = s.ptr + {8'h00, len}; // see RL25
    end
    return o;
  endfunction : sph_read_start
  // ==========================================================================
  // reset release
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign reset_n_sync = rst_sync[1];
  // ==========================================================================
  // link side helpers
  sph_uart_rx u_rx (
    .clock_in       (clock_in),
    .reset_n_in     (reset_n_sync),
    .rx_in          (uart_rx_in),
    .bit_cycles_in  (r.bit_cycles),
    .byte_valid_out (rx_valid),
    .byte_out       (rx_byte)
  );
  sph_fifo2 u_buf (
    .clock_in      (clock_in),
    .reset_n_in    (reset_n_sync),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_data),
    .out_valid_out (tx_valid),
    .out_ready_in  (tx_ready),
    .out_data_out  (tx_data)
  );
  assign tx_ready = (r.tx_bits == 4'h0);
  assign b = r.pkt[r.ep];
  assign wr_step = r.st == sph_pkg::ST_EXEC && r.ep != r.plen && r.need != 8'h00
                   && r.cur[7:4] == sph_pkg::CMD_WR;
  // ==========================================================================
  // engine
  always_comb begin
    logic [10:0] loc;
    loc = sph_locate(r.ptr);
    next_r = r;
    push_valid = 1'b0;
    push_data = 8'h00;
    if (!r.started) begin
      // straps and select pins caught on the first edge after release
      next_r.started = 1'b1;
      next_r.mode = sph_decode_mode(host_if_select_a_in, host_if_select_b_in); // see RL1
      next_r.bit_cycles = sph_bit_cycles(r.ram[sph_pkg::RATE_WORD]); // see RL4 see RL5
      next_r.identity = 8'({r.ram[sph_pkg::ADDR_WORD][5:0], addr_strap_b_in,
                            addr_strap_a_in} + 8'h01); // see RL7
      next_r.selected = !addr_strap_a_in && !addr_strap_b_in; // see RL10
    end
    if (rx_valid && r.started && r.mode == sph_pkg::MODE_UART) begin
      // bytes arriving while executing or replying are dropped
      case (r.st)
        sph_pkg::ST_HUNT: begin
          if (rx_byte == sph_pkg::HDR) begin // see RL14
            next_r.st = sph_pkg::ST_COUNT;
            next_r.sum = rx_byte;
          end
        end
        sph_pkg::ST_COUNT: begin
          next_r.plen = rx_byte - sph_pkg::MIN_COUNT;
          next_r.idx = 8'h00;
          next_r.sum = r.sum + rx_byte;
          if (rx_byte < sph_pkg::MIN_COUNT) begin
            next_r.st = sph_pkg::ST_HUNT; // see RL11
          end else begin
            next_r.st = (rx_byte == sph_pkg::MIN_COUNT) ? sph_pkg::ST_SUM : sph_pkg::ST_BODY;
          end
        end
        sph_pkg::ST_BODY: begin
          next_r.pkt[r.idx] = rx_byte;
          next_r.idx = r.idx + 8'h01;
          next_r.sum = r.sum + rx_byte;
          if (r.idx + 8'h01 == r.plen) begin
            next_r.st = sph_pkg::ST_SUM;
          end
        end
        sph_pkg::ST_SUM: begin
          next_r.was_sel = r.selected;
          next_r.ep = 8'h00;
          next_r.need = 8'h00;
          next_r.rd_req = 1'b0;
          next_r.rp = 9'h000;
          next_r.rsum = 8'h00;
          next_r.fail = (rx_byte != r.sum); // see RL15 see RL11
          next_r.code = sph_pkg::BAD_SUM;
          next_r.st = (rx_byte != r.sum) ? sph_pkg::ST_REPLY : sph_pkg::ST_EXEC;
        end
        default: begin
        end
      endcase
    end
    if (r.st == sph_pkg::ST_EXEC) begin
      if (r.ep == r.plen) begin
        if (r.need != 8'h00) begin
          next_r.fail = 1'b1;
          next_r.code = sph_pkg::OVERFLOW; // see RL23
        end
        next_r.st = sph_pkg::ST_REPLY;
      end else if (r.need == 8'h00) begin
        next_r.ep = r.ep + 8'h01;
        next_r.cur = b;
        if ((!r.was_sel && r.ep != 8'h00)
            || (!r.selected && b[7:4] != sph_pkg::CMD_SEL)) begin
          next_r.st = sph_pkg::ST_REPLY; // see RL17 see RL27
        end else begin
          case (b[7:4])
            sph_pkg::CMD_ADDR: begin
              if (b[3:0] == 4'h0) begin
                next_r.ptr = 16'h0000; // see RL18
              end else if (b[3:0] < 4'h4) begin
                next_r.need = (b[3:0] == 4'h3) ? 8'h02 : 8'h01;
              end else begin
                next_r.fail = 1'b1;
                next_r.code = sph_pkg::NOT_IMPL; // see RL22
                next_r.st = sph_pkg::ST_REPLY;
              end
            end
            sph_pkg::CMD_SEL: begin
              if (b[3:0] == 4'hF) begin
                next_r.need = 8'h01;
              end else begin
                next_r.selected = b[3:0] != 4'h0 && r.identity == {4'h0, b[3:0]}; // see RL19
              end
            end
            sph_pkg::CMD_WR: begin
              next_r.need = (b[3:0] == 4'h0) ? r.plen - r.ep - 8'h01 : {4'h0, b[3:0]}; // see RL20
            end
            sph_pkg::CMD_RD: begin
              if (b[3:0] == 4'h0) begin
                next_r.need = 8'h01;
              end else begin
                next_r = sph_read_start(next_r, {4'h0, b[3:0]}); // see RL21
              end
            end
            default: begin
              next_r.fail = 1'b1;
              next_r.code = sph_pkg::NOT_IMPL; // see RL22
              next_r.st = sph_pkg::ST_REPLY;
            end
          endcase
        end
      end else begin
        next_r.ep = r.ep + 8'h01;
        next_r.need = r.need - 8'h01;
        case (r.cur[7:4])
          sph_pkg::CMD_ADDR: begin
            // the low byte comes first when both are sent
            if (r.cur[3:0] == 4'h2 || (r.cur[3:0] == 4'h3 && r.need == 8'h01)) begin
              next_r.ptr[15:8] = b; // see RL16 see RL18
            end else begin
              next_r.ptr[7:0] = b;
            end
          end
          sph_pkg::CMD_SEL: begin
            next_r.selected = b != 8'h00 && b == r.identity; // see RL9 see RL19
          end
          sph_pkg::CMD_WR: begin
            // writes beyond the user area are dropped but still move the pointer
            if (loc[10]) begin
              next_r.ram[loc[9:2]][{loc[1:0], 3'b000} +: 8] = b; // see RL3 see RL16
            end
            next_r.ptr = r.ptr + 16'h0001; // see RL25
          end
          default: begin
            next_r = sph_read_start(next_r, b); // see RL21
          end
        endcase
      end
    end
    if (r.st == sph_pkg::ST_REPLY) begin
      if (!r.was_sel && !r.selected) begin
        next_r.st = sph_pkg::ST_HUNT; // see RL12
      end else begin
        push_valid = 1'b1;
        if (r.fail) begin
          push_data = r.code; // see RL23
        end else if (!r.rd_req) begin
          push_data = sph_pkg::ACK; // see RL23
        end else if (r.rp == 9'h000) begin
          push_data = sph_pkg::ACK_DATA; // see RL24
        end else if (r.rp == 9'h001) begin
          push_data = r.rd_len + sph_pkg::MIN_COUNT;
        end else if (r.rp == {1'b0, r.rd_len} + 9'h002) begin
          push_data = r.rsum; // see RL15
        end else begin
          push_data = sph_get(r.ram, r.rd_ptr + {7'h00, r.rp} - 16'h0002); // see RL16
        end
        if (push_ready) begin
          next_r.rsum = r.rsum + push_data;
          next_r.rp = r.rp + 9'h001;
          if (r.fail || !r.rd_req || r.rp == {1'b0, r.rd_len} + 9'h002) begin
            next_r.st = sph_pkg::ST_HUNT;
          end
        end
      end
    end
    // transmitter, stalls the buffer while a frame is out
    if (tx_valid && tx_ready) begin
      next_r.tx_sh = {1'b1, tx_data, 1'b0};
      next_r.tx_bits = 4'hA;
      next_r.tx_cnt = r.bit_cycles - 16'h0001;
    end else if (r.tx_bits != 4'h0) begin
      if (r.tx_cnt == 16'h0000) begin
        next_r.tx_sh = {1'b1, r.tx_sh[9:1]};
        next_r.tx_bits = r.tx_bits - 4'h1;
        next_r.tx_cnt = r.bit_cycles - 16'h0001;
      end else begin
        next_r.tx_cnt = r.tx_cnt - 16'h0001;
      end
    end
  end
  always_ff @(posedge clock_in or negedge reset_n_sync) begin
    if (!reset_n_sync) begin
      r <= '0;
      r.ram[sph_pkg::RATE_WORD] <= sph_pkg::RATE_DEFAULT;
      r.ram[sph_pkg::ADDR_WORD] <= sph_pkg::ADDR_RESET;
      r.tx_sh <= 10'h3FF;
    end else begin
      r <= next_r;
    end
  end
  assign uart_tx_out = r.tx_sh[0];
  assign shared_select_direction_pin_out = r.selected && r.mode == sph_pkg::MODE_UART; // see RL6
  assign host_mode_out = r.mode;
  assign target_identity_out = r.identity;
  // ==========================================================================
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_sync);
  mode_latch_a: assert property ( // see RL1
    $rose(r.started) |-> r.mode == sph_decode_mode($past(host_if_select_a_in),
                                                    $past(host_if_select_b_in)))
    else $error("mode not taken from select pins");
  rate_hold_a: assert property ( // see RL5
    r.started && $past(r.started) |-> $stable(r.bit_cycles) && r.bit_cycles >= 16'h0056)
    else $error("bit time changed or over cap");
  strap_sel_a: assert property ( // see RL10
    $rose(r.started) && !$past(addr_strap_a_in) && !$past(addr_strap_b_in)
    |-> r.selected && r.identity == 8'h01)
    else $error("strap default not selected");
  dir_sel_a: assert property ( // see RL6
    r.st == sph_pkg::ST_EXEC && r.ep == 8'h00 && r.ep != r.plen && r.need == 8'h00
    && b[7:4] == sph_pkg::CMD_SEL && b[3:0] != 4'hF && b[3:0] != 4'h0
    && {4'h0, b[3:0]} == r.identity && r.mode == sph_pkg::MODE_UART
    |=> shared_select_direction_pin_out)
    else $error("direction pin does not follow selection");
  zero_id_a: assert property ( // see RL9
    r.st == sph_pkg::ST_EXEC && r.ep != r.plen && r.need == 8'h01 && r.cur == 8'hCF
    && b == 8'h00 |=> !r.selected)
    else $error("identity zero left target selected");
  bad_sum_a: assert property ( // see RL11
    rx_valid && r.started && r.mode == sph_pkg::MODE_UART && r.st == sph_pkg::ST_SUM
    && rx_byte != r.sum |=> r.fail && r.code == 8'hBD && r.st == sph_pkg::ST_REPLY)
    else $error("bad checksum not flagged");
  silent_a: assert property ( // see RL12
    push_valid |-> r.was_sel || r.selected)
    else $error("reply while not selected");
  short_cnt_a: assert property ( // see RL14
    rx_valid && r.mode == sph_pkg::MODE_UART && r.st == sph_pkg::ST_COUNT
    && rx_byte < 8'h03 |=> r.st == sph_pkg::ST_HUNT)
    else $error("short count not dropped");
  data_hdr_a: assert property ( // see RL24
    push_valid && !r.fail && r.rd_req && r.rp < 9'h002
    |-> push_data == ((r.rp == 9'h000) ? 8'hAA : 8'(r.rd_len + 8'h03)))
    else $error("read reply framing wrong");
  ptr_step_a: assert property ( // see RL25
    wr_step |=> r.ptr == $past(r.ptr) + 16'h0001)
    else $error("pointer did not advance on write");
  data_reply_c: cover property (push_valid && push_ready && r.rd_req && r.rp == 9'h002);
  bad_sum_c: cover property (push_valid && r.fail && r.code == 8'hBD);
  deselect_c: cover property ($fell(r.selected));
  write_c: cover property (wr_step);
endmodule : sph_host_if

// ==== bench/sph_host_model.sv ====
// uart master model: sends packet bytes, decodes reply bytes
`timescale 1ns/1ns
module sph_host_model (
  input  wire logic clock_in,
  input  wire logic tx_in,
  output logic      rx_out,
  output logic      got_out,
  output logic [7:0] byte_out
);
  // ==========
  // 8n1 at the reset rate, 260 cycles a bit
  localparam int BIT = 260;
  initial begin
    rx_out = 1'b1;
    got_out = 1'b0;
    byte_out = 8'h00;
  end
  // lsb first; line left high after the stop bit
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_out <= f[i];
      repeat (BIT) @(posedge clock_in);
    end
  endtask : put
  // sample mid bit; a byte without a high stop bit is not reported
  always begin
    @(negedge tx_in);
    repeat (BIT / 2) @(posedge clock_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clock_in);
      byte_out[i] = tx_in;
    end
    repeat (BIT) @(posedge clock_in);
    got_out = tx_in;
    @(posedge clock_in);
    got_out = 1'b0;
  end
endmodule : sph_host_model

// ==== bench/sph_host_if_tb_top.sv ====
// testbench of the serial packet host interface
`timescale 1ns/1ns
module sph_host_if_tb_top;
  logic       clock_in;
  logic       reset_n_in;
  logic       rx;
  logic       tx;
  logic       dir;
  logic [1:0] mode;
  logic [7:0] ident;
  logic       got;
  logic [7:0] rbyte;
  logic [7:0] exp_q[$];
  logic [7:0] d[3];
  logic [7:0] lo;
  logic       sel_a;
  logic       sel_b;
  logic [1:0] strap;
  logic [7:0] id;
  logic [7:0] pl[$];
  int         errors;
  int         tests_run;
  int         cycles;
  int         seed;
  // ==========
  // select pins and straps set anew with every reset
  sph_host_if dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .host_if_select_a_in(sel_a), .host_if_select_b_in(sel_b),
    .addr_strap_a_in(strap[0]), .addr_strap_b_in(strap[1]), .uart_rx_in(rx),
    .uart_tx_out(tx), .shared_select_direction_pin_out(dir),
    .host_mode_out(mode), .target_identity_out(ident));
  sph_host_model host_u (.clock_in(clock_in), .tx_in(tx), .rx_out(rx),
    .got_out(got), .byte_out(rbyte));
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  // ==========
  // checks and verdict
  task automatic test_done;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // pins change only while reset is held, then stay put
  task automatic restart(input logic a, input logic sb, input logic [1:0] st);
    reset_n_in <= 1'b0;
    sel_a <= a;
    sel_b <= sb;
    strap <= st;
    repeat (3) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (6) @(posedge clock_in);
  endtask : restart
  // roughly 39 bytes of 2600 cycles, small margin
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 110000) begin
      errors++;
      test_done();
    end
  end
  always @(posedge got) begin
    if (exp_q.size() == 0) begin
      errors++;
      $display("[ERR] reply expected none seen %h", rbyte);
    end else check("reply", exp_q.pop_front(), rbyte);
  end
  // ==========
  // packet: header, count, payload, sum; bad flips sum bit 0
  task automatic pkt(input logic [7:0] p[$], input logic bad);
    logic [7:0] f[$];
    logic [7:0] s;
    f = {8'hAA, 8'(p.size() + 3), p};
    s = 8'h00;
    foreach (f[i]) s += f[i];
    f.push_back(s ^ {7'h00, bad});
    foreach (f[i]) host_u.put(f[i]);
    for (int i = 0; i < 20000 && exp_q.size() != 0; i++) @(posedge clock_in);
  endtask : pkt
  initial begin
    seed = 32'h10d7;
    errors = 0;
    tests_run = 0;
    cycles = 0;
    restart(1'b1, 1'b0, 2'b00);
    check("mode", 8'h01, {6'h00, mode});
    check("identity", 8'h01, ident);
    check("dir", 8'h01, {7'h00, dir});
    // address word rewritten with its unused bits kept at one
    d[0] = 8'($random(seed)) | 8'hC0;
    d[1] = 8'hFF;
    d[2] = 8'hFF;
    lo = 8'($random(seed)) | 8'h01;
    id = {6'h00, lo[1:0]} + 8'h01;
    exp_q = '{8'hAA, 8'h06, d[0], d[1], d[2], 8'hB0 + d[0] + d[1] + d[2]};
    pl = '{8'hA3, 8'h3D, 8'h02, 8'hD3, d[0], d[1], d[2], 8'hA1, 8'h3D, 8'hE3};
    pkt(pl, 1'b0);
    exp_q.push_back(8'hBD);
    pkt('{8'hA0}, 1'b1);
    exp_q.push_back(8'hAD);
    pkt('{8'hCF, 8'h00}, 1'b0);
    check("dir", 8'h00, {7'h00, dir});
    // a reply would still hold its start bit low here
    pkt('{8'hA0}, 1'b0);
    check("silent", 8'h01, {7'h00, tx});
    restart(1'b1, 1'b1, lo[1:0]);
    check("mode", 8'h02, {6'h00, mode});
    check("dir", 8'h00, {7'h00, dir});
    restart(1'b0, 1'b1, lo[1:0]);
    check("mode", 8'h00, {6'h00, mode});
    restart(1'b1, 1'b0, lo[1:0]);
    check("identity", id, ident);
    check("dir", 8'h00, {7'h00, dir});
    exp_q.push_back(8'hAD);
    pkt('{8'hC0 | id}, 1'b0);
    check("dir", 8'h01, {7'h00, dir});
    test_done();
  end
endmodule : sph_host_if_tb_top
